//--- rtl/pfc_regs.sv
// Purpose: Bridge function control registers and the small logic they steer.
// Assumes: Configuration accesses arrive as one-cycle strobes on ref_clk.
// Notes:   Read data and every output but the tied-low serr_n_out come from flip-flops.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Control one bit 3 enables buffering of PCI slave writes.
// - Control one bit 0 always reads one and ignores writes.
// - Control two bit 7 forces single-beat PCI accesses, else bursts.
// - Control two bit 6 traps IDE function header accesses into SMI.
// - A trapped access sets top status bit 9 and second bit 5.
// - Control two bit 5 makes driven or seen PERR# assert SERR#.
// - Control two bit 4 enables a 16-byte internal-bus to PCI write buffer.
// - Control two bit 3 traps power management header accesses into SMI.
// - Unclaimed PCI cycles are claimed subtractively, timed by control two bits 2:1.
// - Field 00 samples clock four, 01 clock three, 1x disables.
// - Control two bit 0 traps bridge header accesses except indexes 40h-43h.
// - Control three bit 7 routes USB SMI onto the SMI pin.
// - Control three bit 6 routes USB SMI to top status bit 14.
// - Control three bit 5 allows delayed transactions on PCI.
// - Control three bit 4 gives USB DMA priority over other DMA.
// - Control three bit 3 allows target buffering without internal-bus arbitration.
module pfc_regs (
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	// Configuration access from the host.
	input  wire logic                 cfg_rd,
	input  wire logic                 cfg_wr,
	input  wire pfc_pkg::pfc_func_t   cfg_func,
	input  wire logic [7:0]           cfg_idx,
	input  wire logic [7:0]           cfg_wdata,
	output logic [7:0]                cfg_rdata,
	output logic                      cfg_ack,
	output logic                      cfg_trapped,
	// SMI status set pulses toward the power management function.
	output logic                      smi_top_cfg_set,
	output logic                      smi_sec_cfg_set,
	output logic                      smi_top_usb_set,
	input  wire logic                 usb_smi,
	output logic                      sys_mgmt_irq_pin_n,
	// Parity error forwarding; SERR# is open drain.
	input  wire logic                 perr_drive,
	input  wire logic                 perr_n_in,
	output logic                      serr_n_out,
	output logic                      serr_n_oe,
	// Subtractive decode.
	input  wire logic                 frame_n,
	input  wire logic                 devsel_n,
	output logic                      subtr_claim,
	// DMA arbitration.
	input  wire logic                 usb_dma_req,
	input  wire logic                 other_dma_req,
	output logic                      usb_dma_gnt,
	output logic                      other_dma_gnt,
	// Control levels to the bus logic.
	output logic                      intack_resp_en,
	output logic [1:0]                legacy_emul,
	output logic                      slave_wr_buf_en,
	output logic                      single_access_select,
	output logic                      xbus_wr_buf_en,
	output logic [4:0]                xbus_wr_buf_bytes,
	output logic                      delayed_txn_en,
	output logic                      no_arb_buf_en,
	output logic                      hold_req_en
);
	import pfc_pkg::*;

	logic [7:0] ctl1_r, ctl1_nxt;
	logic [7:0] ctl2_r, ctl2_nxt;
	logic [7:0] ctl3_r, ctl3_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic       ack_r, ack_nxt;
	logic       trapped_r, trapped_nxt;
	logic       top_cfg_r, top_cfg_nxt;
	logic       sec_cfg_r, sec_cfg_nxt;
	logic       top_usb_r, top_usb_nxt;
	logic       smi_pin_n_r, smi_pin_n_nxt;
	logic       serr_oe_r, serr_oe_nxt;
	logic       usb_gnt_r, usb_gnt_nxt;
	logic       oth_gnt_r, oth_gnt_nxt;
	logic [4:0] xbytes_r, xbytes_nxt;
	logic       trap_hit;
	logic       claim;
	logic       access;
	logic       own_hit;

	pfc_cfg_if acc_if ();

	// Merge a write under a mask so fixed and reserved bits keep their value.
	function automatic logic [7:0] pfc_merge(input logic [7:0] old_v,
	                                         input logic [7:0] new_v,
	                                         input logic [7:0] mask);
		pfc_merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	// Bridge-function index match.
	function automatic logic pfc_is_reg(input pfc_func_t fn,
	                                    input logic [7:0] idx,
	                                    input logic [7:0] want);
		pfc_is_reg = (fn == PFC_FN_BRIDGE) && (idx == want);
	endfunction

	assign access       = cfg_rd || cfg_wr;
	assign acc_if.valid = access;
	assign acc_if.wr    = cfg_wr;
	assign acc_if.func  = cfg_func;
	assign acc_if.idx   = cfg_idx;

	// Trap decoder on the access path.
	pfc_trap u_trap (
		.acc         (acc_if),
		.br_trap_en  (ctl2_r[PFC_C2_BR_TRAP]),
		.pm_trap_en  (ctl2_r[PFC_C2_PM_TRAP]),
		.ide_trap_en (ctl2_r[PFC_C2_IDE_TRAP]),
		.trap        (trap_hit)
	);

	// Subtractive claim sequencer.
	pfc_subdec u_subdec (
		.ref_clk  (ref_clk),
		.arst_n   (arst_n),
		.mode     (ctl2_r[PFC_C2_SUBDEC_HI:PFC_C2_SUBDEC_LO]),
		.frame_n  (frame_n),
		.devsel_n (devsel_n),
		.claim    (claim)
	);

	// Register writes. A trapped access never updates, but the bank's own
	// indexes are exempt from the trap, so software can always unlock it.
	always_comb begin
		ctl1_nxt = ctl1_r;
		ctl2_nxt = ctl2_r;
		ctl3_nxt = ctl3_r;
		if (cfg_wr && !trap_hit) begin
			if (pfc_is_reg(cfg_func, cfg_idx, PFC_IDX_CTL1)) begin
				ctl1_nxt = pfc_merge(ctl1_r, cfg_wdata, PFC_WMASK_CTL1) | PFC_FIXED_CTL1;
			end
			if (pfc_is_reg(cfg_func, cfg_idx, PFC_IDX_CTL2)) begin
				ctl2_nxt = pfc_merge(ctl2_r, cfg_wdata, PFC_WMASK_CTL2);
			end
			if (pfc_is_reg(cfg_func, cfg_idx, PFC_IDX_CTL3)) begin
				ctl3_nxt = pfc_merge(ctl3_r, cfg_wdata, PFC_WMASK_CTL3);
			end
		end
		// Byte limit is zero while the buffer is off, so writes go straight through.
		xbytes_nxt = ctl2_nxt[PFC_C2_XBUF] ? 5'(PFC_XBUF_BYTES) : 5'h00;
	end

	// Read data and completion. Indexes outside the bank read zero.
	always_comb begin
		own_hit     = pfc_is_reg(cfg_func, cfg_idx, PFC_IDX_CTL1) ||
		              pfc_is_reg(cfg_func, cfg_idx, PFC_IDX_CTL2) ||
		              pfc_is_reg(cfg_func, cfg_idx, PFC_IDX_CTL3);
		rdata_nxt   = 8'h00;
		ack_nxt     = access && !trap_hit && own_hit;
		trapped_nxt = trap_hit;
		if (cfg_rd && !trap_hit) begin
			if (pfc_is_reg(cfg_func, cfg_idx, PFC_IDX_CTL1)) begin
				rdata_nxt = ctl1_r | PFC_FIXED_CTL1;
			end else if (pfc_is_reg(cfg_func, cfg_idx, PFC_IDX_CTL2)) begin
				rdata_nxt = ctl2_r;
			end else if (pfc_is_reg(cfg_func, cfg_idx, PFC_IDX_CTL3)) begin
				rdata_nxt = ctl3_r;
			end
		end
	end

	// SMI reporting. The status registers live in the power management
	// function, so this bank only issues set pulses toward them; the USB one stays high while usb_smi is high and control three bit 6 is set.
	always_comb begin
		top_cfg_nxt   = trap_hit;
		sec_cfg_nxt   = trap_hit;
		top_usb_nxt   = usb_smi && ctl3_r[PFC_C3_USB_STAT];
		smi_pin_n_nxt = !(usb_smi && ctl3_r[PFC_C3_USB_PIN]);
	end

	// SERR# follows parity errors while enabled; open drain, so only the
	// enable moves and the driven level is always low.
	always_comb begin
		serr_oe_nxt = ctl2_r[PFC_C2_PERR_SERR] && (perr_drive || !perr_n_in);
	end

	// DMA arbitration; without priority the other requester wins ties, which
	// keeps the legacy controller's behaviour unchanged by default.
	always_comb begin
		usb_gnt_nxt = 1'b0;
		oth_gnt_nxt = 1'b0;
		if (usb_dma_req && (ctl3_r[PFC_C3_USB_DMA_PRI] || !other_dma_req)) begin
			usb_gnt_nxt = 1'b1;
		end else if (other_dma_req) begin
			oth_gnt_nxt = 1'b1;
		end
	end

	// All state registers.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl1_r      <= PFC_RST_CTL1;
			ctl2_r      <= PFC_RST_CTL2;
			ctl3_r      <= PFC_RST_CTL3;
			rdata_r     <= 8'h00;
			ack_r       <= 1'b0;
			trapped_r   <= 1'b0;
			top_cfg_r   <= 1'b0;
			sec_cfg_r   <= 1'b0;
			top_usb_r   <= 1'b0;
			smi_pin_n_r <= 1'b1;
			serr_oe_r   <= 1'b0;
			usb_gnt_r   <= 1'b0;
			oth_gnt_r   <= 1'b0;
			xbytes_r    <= PFC_RST_CTL2[PFC_C2_XBUF] ? 5'(PFC_XBUF_BYTES) : 5'h00;
		end else begin
			ctl1_r      <= ctl1_nxt;
			ctl2_r      <= ctl2_nxt;
			ctl3_r      <= ctl3_nxt;
			rdata_r     <= rdata_nxt;
			ack_r       <= ack_nxt;
			trapped_r   <= trapped_nxt;
			top_cfg_r   <= top_cfg_nxt;
			sec_cfg_r   <= sec_cfg_nxt;
			top_usb_r   <= top_usb_nxt;
			smi_pin_n_r <= smi_pin_n_nxt;
			serr_oe_r   <= serr_oe_nxt;
			usb_gnt_r   <= usb_gnt_nxt;
			oth_gnt_r   <= oth_gnt_nxt;
			xbytes_r    <= xbytes_nxt;
		end
	end

	// Outputs taken straight from the registers above, except serr_n_out tied low and subtr_claim from the sequencer.
	assign cfg_rdata            = rdata_r;
	assign cfg_ack              = ack_r;
	assign cfg_trapped          = trapped_r;
	assign smi_top_cfg_set      = top_cfg_r;
	assign smi_sec_cfg_set      = sec_cfg_r;
	assign smi_top_usb_set      = top_usb_r;
	assign sys_mgmt_irq_pin_n   = smi_pin_n_r;
	assign serr_n_out           = 1'b0;
	assign serr_n_oe            = serr_oe_r;
	assign subtr_claim          = claim;
	assign usb_dma_gnt          = usb_gnt_r;
	assign other_dma_gnt        = oth_gnt_r;
	assign intack_resp_en       = ctl1_r[PFC_C1_INTACK];
	assign legacy_emul          = ctl1_r[PFC_C1_LEGACY_HI:PFC_C1_LEGACY_LO];
	assign slave_wr_buf_en      = ctl1_r[PFC_C1_WRBUF];
	assign single_access_select = ctl2_r[PFC_C2_SINGLE];
	assign xbus_wr_buf_en       = ctl2_r[PFC_C2_XBUF];
	assign xbus_wr_buf_bytes    = xbytes_r;
	assign delayed_txn_en       = ctl3_r[PFC_C3_DELAYED];
	assign no_arb_buf_en        = ctl3_r[PFC_C3_NO_ARB_BUF];
	assign hold_req_en          = ctl3_r[PFC_C3_HOLD_REQ];
endmodule
`default_nettype wire

//--- rtl/pfc_pkg.sv
// Purpose: Shared constants and types of the bridge function control registers.
// Assumes: Byte-wide configuration accesses on the PCI clock.
// Notes:   Each offset, field position, reset value and count is named once here.
package pfc_pkg;

	// Configuration indexes of the three control registers and of the trap-exempt window.
	localparam logic [7:0] PFC_IDX_CTL1      = 8'h40;
	localparam logic [7:0] PFC_IDX_CTL2      = 8'h41;
	localparam logic [7:0] PFC_IDX_CTL3      = 8'h42;
	localparam logic [7:0] PFC_IDX_TRAP_LO   = 8'h40;
	localparam logic [7:0] PFC_IDX_TRAP_HI   = 8'h43;

	// Reset values.
	localparam logic [7:0] PFC_RST_CTL1      = 8'h89;
	localparam logic [7:0] PFC_RST_CTL2      = 8'h10;
	localparam logic [7:0] PFC_RST_CTL3      = 8'hAC;

	// Writable bits; everything else is fixed or reserved.
	localparam logic [7:0] PFC_WMASK_CTL1    = 8'hF8;
	localparam logic [7:0] PFC_WMASK_CTL2    = 8'hFF;
	localparam logic [7:0] PFC_WMASK_CTL3    = 8'hFF;
	localparam logic [7:0] PFC_FIXED_CTL1    = 8'h01;

	// Control register one fields.
	localparam int PFC_C1_INTACK             = 7;
	localparam int PFC_C1_LEGACY_HI          = 6;
	localparam int PFC_C1_LEGACY_LO          = 5;
	localparam int PFC_C1_WRBUF              = 3;
	localparam int PFC_C1_FIXED_WIDTH        = 0;

	// Control register two fields.
	localparam int PFC_C2_SINGLE             = 7;
	localparam int PFC_C2_IDE_TRAP           = 6;
	localparam int PFC_C2_PERR_SERR          = 5;
	localparam int PFC_C2_XBUF               = 4;
	localparam int PFC_C2_PM_TRAP            = 3;
	localparam int PFC_C2_SUBDEC_HI          = 2;
	localparam int PFC_C2_SUBDEC_LO          = 1;
	localparam int PFC_C2_BR_TRAP            = 0;

	// Control register three fields.
	localparam int PFC_C3_USB_PIN            = 7;
	localparam int PFC_C3_USB_STAT           = 6;
	localparam int PFC_C3_DELAYED            = 5;
	localparam int PFC_C3_USB_DMA_PRI        = 4;
	localparam int PFC_C3_NO_ARB_BUF         = 3;
	localparam int PFC_C3_HOLD_REQ           = 2;

	// Status bit positions in the power management SMI status registers.
	localparam int PFC_TOP_CFG_TRAP_BIT      = 9;
	localparam int PFC_SEC_CFG_TRAP_BIT      = 5;
	localparam int PFC_TOP_USB_BIT           = 14;

	// Depth of the internal-bus to PCI write buffer, in bytes.
	localparam int PFC_XBUF_BYTES            = 16;

	// Subtractive decode sample points, in clocks counted from FRAME# active.
	localparam logic [2:0] PFC_SD_DEFAULT_CLK = 3'h4;
	localparam logic [2:0] PFC_SD_SLOW_CLK    = 3'h3;
	localparam logic [1:0] PFC_SD_MODE_DEFAULT = 2'h0;
	localparam logic [1:0] PFC_SD_MODE_SLOW    = 2'h1;

	// Configuration function numbers of the device.
	typedef enum logic [1:0] {
		PFC_FN_BRIDGE,
		PFC_FN_PM,
		PFC_FN_IDE,
		PFC_FN_OTHER
	} pfc_func_t;

	// Subtractive decode sequencer states.
	typedef enum logic [1:0] {
		PFC_SD_IDLE,
		PFC_SD_COUNT,
		PFC_SD_BUSY
	} pfc_sd_state_t;

endpackage

//--- rtl/pfc_cfg_if.sv
// Purpose: Carries one configuration access from the register bank to its trap decoder.
// Assumes: Signals are valid for the single cycle in which valid is high.
// Notes:   The bank drives the access; the decoder only reads it.
`timescale 1ns/1ps
`default_nettype none
interface pfc_cfg_if;
	import pfc_pkg::*;
	logic       valid;
	logic       wr;
	pfc_func_t  func;
	logic [7:0] idx;

	modport src (output valid, output wr, output func, output idx);
	modport snk (input valid, input wr, input func, input idx);
endinterface
`default_nettype wire

//--- rtl/pfc_trap.sv
// Purpose: Decides whether a configuration access is trapped into an SMI.
// Assumes: Trap enables come from control register two.
// Notes:   Purely combinational; the bank registers the result.
`timescale 1ns/1ps
`default_nettype none
module pfc_trap (
	pfc_cfg_if.snk  acc,
	input  wire logic br_trap_en,
	input  wire logic pm_trap_en,
	input  wire logic ide_trap_en,
	output logic      trap
);
	import pfc_pkg::*;

	// The bridge's own control window stays reachable so a trap can be undone.
	always_comb begin
		trap = 1'b0;
		if (acc.valid) begin
			unique case (acc.func)
				PFC_FN_BRIDGE: trap = br_trap_en &&
					!(acc.idx >= PFC_IDX_TRAP_LO && acc.idx <= PFC_IDX_TRAP_HI);
				PFC_FN_PM:     trap = pm_trap_en;
				PFC_FN_IDE:    trap = ide_trap_en;
				PFC_FN_OTHER:  trap = 1'b0;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- rtl/pfc_subdec.sv
// Purpose: Claims unclaimed PCI cycles at a programmable sample clock.
// Assumes: frame_n and devsel_n are synchronous bus samples.
// Notes:   A claim is a one-cycle pulse on the sample clock.
`timescale 1ns/1ps
`default_nettype none
module pfc_subdec (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic [1:0] mode,
	input  wire logic       frame_n,
	input  wire logic       devsel_n,
	output logic            claim
);
	import pfc_pkg::*;

	pfc_sd_state_t state_r, state_nxt;
	logic [2:0]    cnt_r, cnt_nxt;
	logic          claim_r, claim_nxt;
	logic [2:0]    target;

	// Sample point from the mode field; the upper mode bit disables claiming.
	always_comb begin
		target = (mode == PFC_SD_MODE_SLOW) ? PFC_SD_SLOW_CLK : PFC_SD_DEFAULT_CLK;
	end

	// Count from the clock where FRAME# is first seen; FRAME# may drop before
	// the sample point on a single data phase, so the count does not watch it.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		claim_nxt = 1'b0;
		unique case (state_r)
			PFC_SD_IDLE: begin
				if (!frame_n && !mode[1]) begin
					state_nxt = PFC_SD_COUNT;
					cnt_nxt   = 3'h2;
				end
			end
			PFC_SD_COUNT: begin
				// Disabling mid-count must also stop a claim already on its way.
				if (!devsel_n || mode[1]) begin
					state_nxt = PFC_SD_BUSY;
				end else if (cnt_r == target) begin
					claim_nxt = 1'b1;
					state_nxt = PFC_SD_BUSY;
				end else begin
					cnt_nxt = cnt_r + 3'h1;
				end
			end
			PFC_SD_BUSY: begin
				if (frame_n) begin
					state_nxt = PFC_SD_IDLE;
				end
			end
			default: begin
				state_nxt = PFC_SD_IDLE;
			end
		endcase
	end

	// State registers.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= PFC_SD_IDLE;
			cnt_r   <= 3'h0;
			claim_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			claim_r <= claim_nxt;
		end
	end

	assign claim = claim_r;
endmodule
`default_nettype wire

//--- tb/pfc_regs_assertions.sv
// Purpose: Concurrent checks on the ports of the bridge control register bank.
// Assumes: Bridge indexes 41h and 42h are never trapped, so every write there lands.
// Notes:   Shadow copies of control two and three let enables be judged from ports.
`timescale 1ns/1ps
`default_nettype none
module pfc_regs_assertions
	import pfc_pkg::*;
(
	input wire logic             ref_clk,
	input wire logic             arst_n,
	input wire logic             cfg_rd,
	input wire logic             cfg_wr,
	input wire pfc_pkg::pfc_func_t cfg_func,
	input wire logic [7:0]       cfg_idx,
	input wire logic [7:0]       cfg_wdata,
	input wire logic [7:0]       cfg_rdata,
	input wire logic             cfg_ack,
	input wire logic             cfg_trapped,
	input wire logic             smi_top_cfg_set,
	input wire logic             smi_sec_cfg_set,
	input wire logic             smi_top_usb_set,
	input wire logic             usb_smi,
	input wire logic             sys_mgmt_irq_pin_n,
	input wire logic             perr_drive,
	input wire logic             perr_n_in,
	input wire logic             serr_n_out,
	input wire logic             serr_n_oe,
	input wire logic             frame_n,
	input wire logic             devsel_n,
	input wire logic             subtr_claim,
	input wire logic             usb_dma_req,
	input wire logic             usb_dma_gnt,
	input wire logic             other_dma_gnt,
	input wire logic             xbus_wr_buf_en,
	input wire logic [4:0]       xbus_wr_buf_bytes
);
	logic [7:0] c2_r, c2_nxt, c3_r, c3_nxt;
	logic       hit;

	// Mirror bank writes; a read strobed with a write still lets the write land.
	always_comb begin
		hit = cfg_wr && cfg_func == PFC_FN_BRIDGE;
		c2_nxt = (hit && cfg_idx == PFC_IDX_CTL2) ? cfg_wdata : c2_r;
		c3_nxt = (hit && cfg_idx == PFC_IDX_CTL3) ? cfg_wdata : c3_r;
	end

	// Shadow registers reset with the bank.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			c2_r <= PFC_RST_CTL2;
			c3_r <= PFC_RST_CTL3;
		end else begin
			c2_r <= c2_nxt;
			c3_r <= c3_nxt;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	a_bank_ack: assert property ((cfg_rd || cfg_wr) && cfg_func == PFC_FN_BRIDGE &&
		cfg_idx >= PFC_IDX_CTL1 && cfg_idx <= PFC_IDX_CTL3 |=> cfg_ack && !cfg_trapped)
		else $error("bank access not acknowledged");
	a_fixed_width: assert property (cfg_rd && cfg_func == PFC_FN_BRIDGE &&
		cfg_idx == PFC_IDX_CTL1 |=> cfg_rdata[2:0] == 3'h1)
		else $error("fixed width bit or reserved bits wrong");
	a_trap_status: assert property (cfg_trapped |-> smi_top_cfg_set &&
		smi_sec_cfg_set && cfg_rdata == 8'h00 && !cfg_ack)
		else $error("trapped access status wrong");
	a_func_trap: assert property ((cfg_rd || cfg_wr) &&
		((cfg_func == PFC_FN_IDE && c2_r[6]) || (cfg_func == PFC_FN_PM && c2_r[3]))
		|=> cfg_trapped)
		else $error("function header access not trapped");
	a_serr_fwd: assert property (1'b1 |=> !serr_n_out &&
		serr_n_oe == $past(c2_r[5] && (perr_drive || !perr_n_in)))
		else $error("SERR forwarding wrong");
	a_smi_pin: assert property (1'b1 |=>
		sys_mgmt_irq_pin_n == !$past(usb_smi && c3_r[7]))
		else $error("SMI pin wrong");
	a_usb_status: assert property (usb_smi && c3_r[6] |=> smi_top_usb_set)
		else $error("USB status set missing");
	a_sd_default: assert property ($fell(frame_n) && c2_r[2:1] == 2'h0 ##1
		devsel_n [*3] |=> subtr_claim)
		else $error("default sample claim missing");
	a_sd_slow: assert property ($fell(frame_n) && c2_r[2:1] == 2'h1 ##1
		devsel_n [*2] |=> subtr_claim)
		else $error("slow sample claim missing");
	a_sd_early: assert property ($fell(frame_n) |=> !subtr_claim [*2])
		else $error("claim too early");
	a_sd_off: assert property (c2_r[2] && $past(c2_r[2]) |-> !subtr_claim)
		else $error("claim while disabled");
	a_dma_pri: assert property (usb_dma_req && c3_r[4] |=>
		usb_dma_gnt && !other_dma_gnt)
		else $error("USB DMA did not win");
	a_xbuf_depth: assert property (xbus_wr_buf_bytes ==
		(xbus_wr_buf_en ? 5'h10 : 5'h00))
		else $error("buffer depth wrong");
endmodule

bind pfc_regs pfc_regs_assertions i_pfc_regs_assertions (.*);
`default_nettype wire

//--- tb/pfc_bus_agent.sv
// Purpose: Other PCI agents: starts frames and may claim them by positive decode.
// Assumes: go is a one-clock request; early asks for a fast DEVSEL claim.
// Notes:   Released lines return high, as the bus pull-ups make them.
`timescale 1ns/1ps
`default_nettype none
module pfc_bus_agent (
	input  wire logic ref_clk,
	input  wire logic go,
	input  wire logic early,
	output logic      frame_n,
	output logic      devsel_n
);
	int   cnt;
	logic act;

	assign act = cnt >= 1 && cnt <= 6;

	initial begin
		cnt = 0;
		frame_n = 1'b1;
		devsel_n = 1'b1;
	end

	// FRAME# stays low long past both sample points so a claim is never cut short.
	always @(posedge ref_clk) begin
		frame_n <= !(go || act);
		devsel_n <= !(early && act);
		cnt <= (go && cnt == 0) ? 1 : (cnt == 0 || cnt == 8) ? 0 : cnt + 1;
	end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: Self-checking bench for the bridge function control registers.
// Assumes: One-clock configuration strobes, answers one clock later.
// Notes:   Expected values come from the field layout, never from the design.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pfc_pkg::*;
	logic       ref_clk, arst_n, cfg_rd, cfg_wr, cfg_ack, cfg_trapped;
	pfc_func_t  cfg_func;
	logic [7:0] cfg_idx, cfg_wdata, cfg_rdata, st, rd, v;
	logic       smi_top_cfg_set, smi_sec_cfg_set, smi_top_usb_set, usb_smi;
	logic       sys_mgmt_irq_pin_n, perr_drive, perr_n_in, serr_n_out, serr_n_oe;
	logic       frame_n, devsel_n, subtr_claim, go, early, intack_resp_en;
	logic       usb_dma_req, other_dma_req, usb_dma_gnt, other_dma_gnt;
	logic       slave_wr_buf_en, single_access_select, xbus_wr_buf_en;
	logic       delayed_txn_en, no_arb_buf_en, hold_req_en;
	logic [1:0] legacy_emul;
	logic [4:0] xbus_wr_buf_bytes;
	int         errors, checked, got;
	logic [7:0] rv [3] = '{PFC_RST_CTL1, PFC_RST_CTL2, PFC_RST_CTL3};
	logic [39:0] tr [7] = '{40'h40_02_08_07_00, 40'h08_01_10_07_00,
		40'h08_02_00_00_00, 40'h01_00_04_07_00, 40'h01_00_43_00_00,
		40'h01_00_42_08_AC, 40'h01_03_00_00_00};
	logic [15:0] sd [5] = '{16'h00_05, 16'h02_04, 16'h04_00, 16'h06_00, 16'h80_00};
	logic [7:0] c3v [3] = '{8'h40, 8'hBC, 8'hAC};

	pfc_regs i_pfc_regs (.*);
	pfc_bus_agent i_pfc_bus_agent (.*);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// One access; the strobe stands one clock, the answer is taken just after.
	task automatic acc(input logic w, input pfc_func_t f, input logic [7:0] i,
		input logic [7:0] d);
		@(posedge ref_clk);
		cfg_wr <= w;
		cfg_rd <= !w;
		cfg_func <= f;
		cfg_idx <= i;
		cfg_wdata <= d;
		@(posedge ref_clk);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b0;
		#1;
		rd = cfg_rdata;
		st = {4'h0, cfg_ack, cfg_trapped, smi_top_cfg_set, smi_sec_cfg_set};
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// A hang counts as a mismatch; the whole run needs well under this.
	initial begin
		#100000;
		errors++;
		wrap_up();
	end

	initial begin
		{cfg_rd, cfg_wr, usb_smi, perr_drive, usb_dma_req, other_dma_req} = '0;
		{go, early, arst_n} = '0;
		cfg_func = PFC_FN_BRIDGE;
		cfg_idx = 8'h00;
		cfg_wdata = 8'h00;
		perr_n_in = 1'b1;
		errors = 0;
		checked = 0;
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			acc(1'b0, PFC_FN_BRIDGE, PFC_IDX_CTL1 + 8'(k), 8'h00);
			chk(rd, rv[k]);
			chk(st, 8'h08);
		end
		$display("reset values done");
		// Software keeps bits 6:5 clear; bits 2:1 written as ones, bit 0 as zero, stay fixed.
		for (int k = 0; k < 2; k++) begin
			v = k ? 8'h81 : 8'h1E;
			acc(1'b1, PFC_FN_BRIDGE, PFC_IDX_CTL1, v);
			acc(1'b0, PFC_FN_BRIDGE, PFC_IDX_CTL1, 8'h00);
			chk(rd, (v & 8'hF8) | 8'h01);
			chk({4'h0, intack_resp_en, legacy_emul, slave_wr_buf_en}, {4'h0, v[7], 2'h0, v[3]});
			v = k ? 8'h00 : 8'h90;
			acc(1'b1, PFC_FN_BRIDGE, PFC_IDX_CTL2, v);
			chk({single_access_select, xbus_wr_buf_en, 1'b0, xbus_wr_buf_bytes},
				{v[7], v[4], 1'b0, v[4] ? 5'h10 : 5'h00});
		end
		$display("control fields done");
		for (int k = 0; k < 7; k++) begin
			acc(1'b1, PFC_FN_BRIDGE, PFC_IDX_CTL2, tr[k][39:32]);
			acc(1'b0, pfc_func_t'(tr[k][25:24]), tr[k][23:16], 8'h00);
			chk(st, tr[k][15:8]);
			chk(rd, tr[k][7:0]);
		end
		$display("traps done");
		for (int k = 0; k < 4; k++) begin
			acc(1'b1, PFC_FN_BRIDGE, PFC_IDX_CTL2, k[1] ? 8'h20 : 8'h00);
			@(posedge ref_clk);
			perr_drive <= k[0];
			perr_n_in <= k[0];
			tick(2);
			chk({6'h0, serr_n_oe, serr_n_out}, {6'h0, k[1], 1'b0});
			@(posedge ref_clk);
			perr_drive <= 1'b0;
			perr_n_in <= 1'b1;
			tick(2);
			chk({6'h0, serr_n_oe, serr_n_out}, 8'h00);
		end
		$display("parity forwarding done");
		@(posedge ref_clk);
		usb_smi <= 1'b1;
		usb_dma_req <= 1'b1;
		other_dma_req <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			v = c3v[k];
			acc(1'b1, PFC_FN_BRIDGE, PFC_IDX_CTL3, v);
			tick(2);
			chk({6'h0, sys_mgmt_irq_pin_n, smi_top_usb_set}, {6'h0, !v[7], v[6]});
			chk({5'h0, hold_req_en, delayed_txn_en, no_arb_buf_en}, {5'h0, v[2], v[5], v[3]});
			chk({6'h0, usb_dma_gnt, other_dma_gnt}, {6'h0, v[4], !v[4]});
		end
		$display("usb and dma done");
		// Disabling subtractive decode is tried only here, on an idle bus.
		for (int k = 0; k < 5; k++) begin
			acc(1'b1, PFC_FN_BRIDGE, PFC_IDX_CTL2, {1'b0, sd[k][14:8]});
			@(posedge ref_clk);
			go <= 1'b1;
			early <= sd[k][15];
			@(posedge ref_clk);
			go <= 1'b0;
			got = 0;
			for (int j = 2; j <= 12; j++) begin
				@(posedge ref_clk);
				#1;
				if (subtr_claim === 1'b1) got = got * 16 + j;
			end
			chk(8'(got), sd[k][7:0]);
		end
		$display("subtractive decode done");
		// A second reset mid-run must bring every register back to its reset value.
		@(posedge ref_clk);
		arst_n <= 1'b0;
		usb_smi <= 1'b0;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			acc(1'b0, PFC_FN_BRIDGE, PFC_IDX_CTL1 + 8'(k), 8'h00);
			chk(rd, rv[k]);
		end
		$display("second reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
